// ===== hw/vpf_core.sv
// voice activity energy core: filtered energy, threshold update and tone pole screen
`timescale 1ns/10ps
module vpf_core #(
    parameter int unsigned LAGS = 9
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire vpf_pkg::vpf_frame_t frame_i,
    input wire vpf_pkg::vpf_pf_t adapt_factor_i,
    input wire logic threshold_load_i,
    input wire vpf_pkg::vpf_pf_t threshold_i,
    output logic busy_o,
    output logic done_o,
    output vpf_pkg::vpf_pf_t filtered_energy_o,
    output vpf_pkg::vpf_pf_t threshold_o,
    output vpf_pkg::vpf_pf_t input_energy_o,
    output logic below_floor_o,
    output logic vad_decision_o,
    output logic signed [16:0] pole_real_part_o,
    output logic signed [35:0] pole_imaginary_term_o,
    output logic tone_o
);
    import vpf_pkg::*;

    if (LAGS != LAG_COUNT)
    begin : g_bad_lags
        $error("vpf_core: LAGS must equal the eighth-order lag count");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    vpf_state_t state_ff, nxt_state;
    vpf_frame_t frame_ff;
    logic [3:0] idx_ff, nxt_idx;
    logic signed [63:0] acc_ff, nxt_acc;
    vpf_pf_t pvad_ff, thvad_ff, input_energy_ff;
    logic floor_ff, decision_ff, tone_ff, done_ff;
    logic signed [16:0] re_ff;
    logic signed [35:0] im_ff;

    ////////////////////////////////////////////////////////////////////////////
    // lagged energy accumulation, one product per cycle
    wire logic signed [15:0] lag_r = $signed(frame_ff.r[idx_ff]);
    wire logic signed [31:0] lag_acf = $signed(frame_ff.acf[idx_ff]);
    wire logic signed [47:0] lag_prod = lag_r * lag_acf;
    // the eight lag pairs each appear twice in the squared filter output
    wire logic signed [63:0] lag_term = (idx_ff == 4'h0) ? 64'(lag_prod) : 64'(lag_prod) <<< 1;
    wire logic last_lag = (idx_ff == 4'(LAG_COUNT - 1));
    wire logic signed [63:0] acc_sum = acc_ff + lag_term;
    // a negative sum can only come from bad inputs; clamp instead of wrapping
    wire logic [63:0] acc_pos = acc_sum[63] ? 64'h0 : acc_sum;
    wire vpf_pf_t pvad_norm = vpf_norm(acc_pos, 16'sh0000);
    wire logic [31:0] input_energy_raw = frame_ff.acf[0];
    wire logic [63:0] input_energy_pos = input_energy_raw[31] ? 64'h0 : {32'h0, input_energy_raw};
    wire vpf_pf_t input_energy_norm = vpf_norm(input_energy_pos, 16'sh0000);

    ////////////////////////////////////////////////////////////////////////////
    // the single pseudo-float addition: upper limit = pvad + margin
    wire logic signed [15:0] add_diff = pvad_ff.exp - PF_MARGIN.exp;
    wire logic add_a_big = !add_diff[15];
    wire vpf_pf_t add_big = add_a_big ? pvad_ff : PF_MARGIN;
    wire vpf_pf_t add_small = add_a_big ? PF_MARGIN : pvad_ff;
    wire logic [15:0] add_mag = add_a_big ? add_diff : 16'(-add_diff);
    wire logic [4:0] add_shift = (add_mag > MAX_ALIGN) ? 5'h1f : add_mag[4:0];
    wire logic [32:0] add_sum = {1'b0, add_big.mant, 16'h0} + ({1'b0, add_small.mant, 16'h0} >> add_shift);
    wire vpf_pf_t upper_limit = vpf_norm({31'h0, add_sum}, add_big.exp - ADD_BASE_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // the single pseudo-float multiplication: threshold times adaptation factor
    wire logic [31:0] mul_prod = thvad_ff.mant * adapt_factor_i.mant;
    wire logic signed [15:0] mul_base = thvad_ff.exp + adapt_factor_i.exp - MUL_BASE_OFS;
    wire vpf_pf_t scaled_th = vpf_norm({32'h0, mul_prod}, mul_base);

    // lower of the scaled threshold and the limit; floor case forces lower level
    wire vpf_pf_t capped_th = vpf_lt(upper_limit, scaled_th) ? upper_limit : scaled_th;
    wire logic below_floor = vpf_lt(input_energy_ff, PF_FLOOR);
    wire vpf_pf_t new_th = below_floor ? PF_LOWER : capped_th;

    ////////////////////////////////////////////////////////////////////////////
    // second-order pole screen
    wire logic signed [31:0] rc_prod = frame_ff.rc1 * frame_ff.rc2;
    wire logic signed [16:0] a1 = 17'(frame_ff.rc1) + 17'(rc_prod >>> 15);
    wire logic signed [15:0] a2 = frame_ff.rc2;
    wire logic signed [33:0] a1_sq = a1 * a1;
    wire logic signed [35:0] four_a2 = 36'(a2) <<< 17;
    wire logic signed [35:0] im_num = four_a2 - 36'(a1_sq);
    wire logic signed [16:0] re_val = 17'(-a1) >>> 1;
    wire logic im_neg = im_num[35];
    wire logic re_neg = re_val[16];
    wire logic signed [51:0] freq_lhs = 52'(im_num) <<< 15;
    wire logic signed [51:0] freq_rhs = 52'(FREQ_TH_Q15) * 52'(a1_sq);
    wire logic low_pole = freq_lhs < freq_rhs;
    // zero real part is treated as the positive branch
    wire logic run_pred = !im_neg && (re_neg || !low_pole);
    wire logic tone_hit = run_pred && (frame_ff.pred_err < PRED_TH_Q15);

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_acc = acc_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    nxt_state = ST_MAC;
                    nxt_idx = 4'h0;
                    nxt_acc = 64'sh0;
                end
            end
            ST_MAC:
            begin
                nxt_acc = acc_sum;
                nxt_idx = idx_ff + 4'h1;
                if (last_lag)
                begin
                    nxt_state = ST_ARITH;
                end
            end
            ST_ARITH:
            begin
                nxt_state = ST_DONE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= 4'h0;
            acc_ff <= 64'sh0;
            frame_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            acc_ff <= nxt_acc;
            if (state_ff == ST_IDLE && start_i)
            begin
                frame_ff <= frame_i;
            end
        end
    end

    // energies are normalised once the last lag is summed
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pvad_ff <= '{exp: 16'sh0000, mant: MANT_MIN};
            input_energy_ff <= '{exp: 16'sh0000, mant: MANT_MIN};
        end
        else if (state_ff == ST_MAC && last_lag)
        begin
            pvad_ff <= pvad_norm;
            input_energy_ff <= input_energy_norm;
        end
    end

    // a software load overrides the frame update when both land together
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            thvad_ff <= PF_LOWER;
        end
        else if (threshold_load_i)
        begin
            thvad_ff <= threshold_i;
        end
        else if (state_ff == ST_ARITH)
        begin
            thvad_ff <= new_th;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            floor_ff <= 1'b0;
            decision_ff <= 1'b0;
            tone_ff <= 1'b0;
            re_ff <= 17'sh0;
            im_ff <= 36'sh0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= (state_ff == ST_ARITH);
            if (state_ff == ST_ARITH)
            begin
                floor_ff <= below_floor;
                decision_ff <= vpf_lt(thvad_ff, pvad_ff);
                tone_ff <= tone_hit;
                re_ff <= re_val;
                im_ff <= im_num >>> 2;
            end
        end
    end

    assign busy_o = (state_ff != ST_IDLE);
    assign done_o = done_ff;
    assign filtered_energy_o = pvad_ff;
    assign threshold_o = thvad_ff;
    assign input_energy_o = input_energy_ff;
    assign below_floor_o = floor_ff;
    assign vad_decision_o = decision_ff;
    assign pole_real_part_o = re_ff;
    assign pole_imaginary_term_o = im_ff;
    assign tone_o = tone_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_frame_start;
        state_ff == ST_IDLE && start_i;
    endsequence

    sequence s_frame_end;
        ##11 done_o;
    endsequence

    chk_frame_latency: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_frame_start |-> s_frame_end)
        else $error("frame did not finish eleven cycles after start");

    chk_mac_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_frame_start |=> (state_ff == ST_MAC) [*8] ##1 (state_ff == ST_MAC) ##1 (state_ff == ST_ARITH))
        else $error("lag accumulation did not last nine cycles");

    chk_pvad_norm: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        filtered_energy_o.mant >= MANT_MIN && filtered_energy_o.mant[15] == 1'b0)
        else $error("filtered energy mantissa not normalised");

    chk_thvad_norm: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $changed(thvad_ff) && !$past(threshold_load_i) |-> thvad_ff.mant >= MANT_MIN)
        else $error("threshold mantissa not normalised after update");

    chk_floor_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_ARITH && below_floor && !threshold_load_i |=> thvad_ff == PF_LOWER)
        else $error("threshold not forced to lower level below floor");

    chk_thvad_cap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_ARITH && !below_floor && !threshold_load_i |=> !vpf_lt($past(upper_limit), thvad_ff))
        else $error("threshold exceeds energy plus margin");

    chk_no_tone_real: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        done_o && pole_imaginary_term_o < 0 |-> !tone_o)
        else $error("tone flagged with real poles");

    chk_low_pole: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_ARITH && !im_neg && !re_neg && low_pole |=> !tone_o)
        else $error("tone flagged below low pole limit");

    chk_pred_tone: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == ST_ARITH && re_neg && !im_neg |=> tone_o == ($past(frame_ff.pred_err) < PRED_TH_Q15))
        else $error("prediction error test gave wrong tone flag");

    chk_decision: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        done_o |-> vad_decision_o == (pvad_ff.exp > $past(thvad_ff.exp) ||
            (pvad_ff.exp == $past(thvad_ff.exp) && pvad_ff.mant > $past(thvad_ff.mant))))
        else $error("decision does not follow exponent first compare");

endmodule : vpf_core

// ===== hw/vpf_pkg.sv
// constants, types and arithmetic helpers for the pseudo-float energy and pole test core
package vpf_pkg;

    localparam int unsigned FILTER_ORDER = 8;
    localparam int unsigned LAG_COUNT = FILTER_ORDER + 1;
    localparam int unsigned FRAME_SAMPLES = 160;
    localparam int unsigned FILTER_OUTPUTS = FRAME_SAMPLES + FILTER_ORDER;
    localparam int unsigned MANT_BITS = 16;
    localparam logic [15:0] MANT_MIN = 16'h4000;
    localparam logic [15:0] MANT_ONE_SHIFT = 16'h000f;

    // stored pseudo-float constants
    localparam logic signed [15:0] E_FLOOR = 16'sh0012;
    localparam logic [15:0] M_FLOOR = 16'h668a;
    localparam logic signed [15:0] E_MARGIN = 16'sh001b;
    localparam logic [15:0] M_MARGIN = 16'h6acf;
    localparam logic signed [15:0] E_LOWER = 16'sh0014;
    localparam logic [15:0] M_LOWER = 16'h445c;

    // tone screen thresholds in q15
    localparam logic signed [15:0] FREQ_TH_Q15 = 16'sh0c74;
    localparam logic signed [15:0] PRED_TH_Q15 = 16'sh05b9;

    // unit exponent offsets of the fixed point intermediates
    localparam logic signed [15:0] ADD_BASE_OFS = 16'sh001f;
    localparam logic signed [15:0] MUL_BASE_OFS = 16'sh001e;
    localparam logic [15:0] MAX_ALIGN = 16'h001f;

    typedef struct packed {
        logic signed [15:0] exp;
        logic [15:0] mant;
    } vpf_pf_t;

    typedef struct packed {
        logic [LAG_COUNT-1:0][31:0] acf;
        logic [LAG_COUNT-1:0][15:0] r;
        logic signed [15:0] rc1;
        logic signed [15:0] rc2;
        logic signed [15:0] pred_err;
    } vpf_frame_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MAC,
        ST_ARITH,
        ST_DONE
    } vpf_state_t;

    localparam vpf_pf_t PF_FLOOR = '{exp: E_FLOOR, mant: M_FLOOR};
    localparam vpf_pf_t PF_MARGIN = '{exp: E_MARGIN, mant: M_MARGIN};
    localparam vpf_pf_t PF_LOWER = '{exp: E_LOWER, mant: M_LOWER};

    // value = mant * 2^(exp-15); base is the exponent of bit 0 of v
    function automatic vpf_pf_t vpf_norm(input logic [63:0] v, input logic signed [15:0] base);
        vpf_pf_t res;
        logic [63:0] sh;
        logic [6:0] top;
        top = 7'h00;
        sh = 64'h0;
        res.exp = base;
        res.mant = MANT_MIN;
        for (int i = 0; i < 64; i++)
        begin
            if (v[i])
            begin
                top = 7'(i + 1);
            end
        end
        if (top != 7'h00)
        begin
            sh = v << (7'h40 - top);
            res.exp = base + $signed({9'h000, top});
            res.mant = {1'b0, sh[63:49]};
        end
        return res;
    endfunction : vpf_norm

    function automatic logic vpf_lt(input vpf_pf_t a, input vpf_pf_t b);
        if (a.exp != b.exp)
        begin
            return a.exp < b.exp;
        end
        return a.mant < b.mant;
    endfunction : vpf_lt

endpackage : vpf_pkg

// ===== dv/vpf_enc_model.sv
// speech encoder stand-in handing one frame per start request
`timescale 1ns/10ps
module vpf_enc_model (
    input wire logic sys_clk_i,
    input wire logic send_i,
    input wire logic busy_i,
    input wire vpf_pkg::vpf_frame_t frame_in_i,
    output logic start_o,
    output vpf_pkg::vpf_frame_t frame_o
);
    import vpf_pkg::*;
    initial start_o = 1'b0;
    initial frame_o = '0;
    // request held until taken; afterwards lines scrambled, not left stale
    always @(posedge sys_clk_i)
    begin
        if (start_o && !busy_i)
        begin
            start_o <= 1'b0;
            frame_o <= ~frame_o;
        end
        else if (send_i && !start_o)
        begin
            start_o <= 1'b1;
            frame_o <= frame_in_i;
        end
    end
endmodule : vpf_enc_model

// ===== dv/vpf_core_tb.sv
// self-checking bench for the pseudo-float energy and pole test core
`timescale 1ns/10ps
module vpf_core_tb;
    import vpf_pkg::*;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
    localparam vpf_pf_t ZERO = '{exp: 16'sh0000, mant: 16'h4000};
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic send = 1'b0;
    logic threshold_load_i = 1'b0;
    vpf_pf_t threshold_i = ZERO;
    vpf_pf_t adapt_factor_i = '{exp: 16'sh0001, mant: 16'h4000};
    vpf_frame_t frm = '0;
    vpf_frame_t frame_i;
    logic start_i, busy_o, done_o, below_floor_o, vad_decision_o, tone_o;
    vpf_pf_t filtered_energy_o, threshold_o, input_energy_o;
    logic signed [16:0] pole_real_part_o;
    logic signed [35:0] pole_imaginary_term_o;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 32'h0a3c;
    int cyc = 0;
    int t, br, e_re;
    longint e_im;
    vpf_pf_t thr_m, e_fe, e_ie, e_thr;
    logic e_bf, e_vad, e_tone, e_even;
    logic signed [15:0] dr1 [5] = '{16'sh4000, 16'sh2000, 16'sh2000, -16'sh7c00, -16'sh7000};
    logic signed [15:0] dr2 [5] = '{16'sh0000, 16'sh4000, 16'sh4000, 16'sh7fff, 16'sh7000};
    logic [15:0] dpe [5] = '{16'h0000, 16'h0000, 16'h05b9, 16'h0000, 16'h0000};
    logic [31:0] fl [3] = '{32'd209999, 32'd210000, 32'hffff0000};
    always #10 sys_clk_i = ~sys_clk_i;
    vpf_enc_model enc_u (.sys_clk_i(sys_clk_i), .send_i(send), .busy_i(busy_o), .frame_in_i(frm),
        .start_o(start_i), .frame_o(frame_i));
    vpf_core #(.LAGS(9)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .frame_i(frame_i),
        .adapt_factor_i(adapt_factor_i), .threshold_load_i(threshold_load_i), .threshold_i(threshold_i),
        .busy_o(busy_o), .done_o(done_o), .filtered_energy_o(filtered_energy_o), .threshold_o(threshold_o),
        .input_energy_o(input_energy_o), .below_floor_o(below_floor_o), .vad_decision_o(vad_decision_o),
        .pole_real_part_o(pole_real_part_o), .pole_imaginary_term_o(pole_imaginary_term_o), .tone_o(tone_o));
    ////////////////////////////////////////
    function automatic vpf_pf_t nrm(input logic [63:0] v, input int b);
        vpf_pf_t r;
        int k;
        k = 0;
        for (int i = 0; i < 64; i++)
            if (v[i])
                k = i + 1;
        r.exp = 16'(b + k);
        r.mant = (k == 0) ? 16'h4000 : 16'(k > 15 ? v >> (k - 15) : v << (15 - k));
        return r;
    endfunction : nrm
    function automatic logic plt(input vpf_pf_t a, input vpf_pf_t b);
        return (a.exp != b.exp) ? ($signed(a.exp) < $signed(b.exp)) : (a.mant < b.mant);
    endfunction : plt
    // exact sum then truncate: matches hardware at any exponent gap, since alignment drops only bits the truncation discards
    task predict;
        longint s, n, a1;
        vpf_pf_t mu, ad;
        int mn, ef;
        s = 0;
        for (int i = 0; i < 9; i++)
            s += (i == 0 ? 1 : 2) * longint'($signed(frm.r[i])) * longint'($signed(frm.acf[i]));
        e_ie = $signed(frm.acf[0]) < 0 ? ZERO : nrm(64'(frm.acf[0]), 0);
        e_fe = s < 0 ? ZERO : nrm(s, 0);
        e_bf = plt(e_ie, PF_FLOOR);
        e_vad = plt(thr_m, e_fe);
        mu = nrm(64'(thr_m.mant) * 64'(adapt_factor_i.mant),
            int'($signed(thr_m.exp)) + int'($signed(adapt_factor_i.exp)) - 30);
        ef = int'($signed(e_fe.exp));
        mn = ef < int'(E_MARGIN) ? ef : int'(E_MARGIN);
        ad = nrm((64'(e_fe.mant) << (ef - mn)) + (64'(M_MARGIN) << (int'(E_MARGIN) - mn)), mn - 15);
        e_thr = e_bf ? PF_LOWER : (plt(ad, mu) ? ad : mu);
        thr_m = e_thr;
        a1 = longint'($signed(frm.rc1)) + ((longint'($signed(frm.rc1)) * longint'($signed(frm.rc2))) >>> 15);
        n = 4 * 32768 * longint'($signed(frm.rc2)) - a1 * a1;
        e_re = int'(-a1 / 2);
        e_im = n / 4;
        e_even = !a1[0];
        br = n < 0 ? 0 : (a1 > 0 ? 1 : (n * 32768 < 3188 * a1 * a1 ? 2 : 3));
        e_tone = (br == 1 || br == 3) ? (frm.pred_err < 16'd1465) : 1'b0;
    endtask : predict
    task check;
        int k;
        k = 0;
        do @(negedge sys_clk_i); while (done_o !== 1'b1 && ++k < 40);
        `CHK("done", 1'b1, done_o)
        // the done cycle is its own state, so busy still stands while done is high
        `CHK("busy", 1'b1, busy_o)
        `CHK("filt_energy", e_fe, filtered_energy_o)
        `CHK("in_energy", e_ie, input_energy_o)
        `CHK("mant_norm", 1'b1, filtered_energy_o.mant >= 16'h4000)
        `CHK("threshold", e_thr, threshold_o)
        `CHK("below_floor", e_bf, below_floor_o)
        `CHK("vad", e_vad, vad_decision_o)
        if (e_even) `CHK("real", 17'(e_re), pole_real_part_o)
        if (e_even) `CHK("imag", 36'(e_im), pole_imaginary_term_o)
        case (br)
            0: `CHK("tone", e_tone, tone_o)
            1: `CHK("tone", e_tone, tone_o)
            2: `CHK("tone", e_tone, tone_o)
            default: `CHK("tone", e_tone, tone_o)
        endcase
    endtask : check
    task start;
        @(posedge sys_clk_i) send <= 1'b1;
        @(posedge sys_clk_i) send <= 1'b0;
    endtask : start
    task run;
        start();
        predict();
        check();
    endtask : run
    task gen(input logic [31:0] a0);
        frm.acf[0] = a0;
        for (int i = 1; i < 9; i++)
        begin
            frm.acf[i] = a0[31] ? 32'h0 : $unsigned($random(seed)) % (a0 + 1);
            frm.r[i] = 16'($signed(8'($random(seed))));
        end
        frm.r[0] = 16'h2000 | 16'($random(seed) & 32'h0fff);
        frm.rc1 = 16'($random(seed));
        frm.rc2 = 16'($random(seed));
        frm.pred_err = 16'($unsigned($random(seed)) % 3000);
    endtask : gen
    task load(input vpf_pf_t v);
        @(posedge sys_clk_i) threshold_load_i <= 1'b1;
        threshold_i <= v;
        @(posedge sys_clk_i) threshold_load_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("load", v, threshold_o)
        thr_m = v;
    endtask : load
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    // ceiling well above the roughly 800 cycles the sequence needs
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            $display("mismatch cycle_limit exp %0d got %0d", 4999, cyc);
            conclude();
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("rst_threshold", PF_LOWER, threshold_o)
        `CHK("rst_energy", ZERO, input_energy_o)
        thr_m = PF_LOWER;
        $display("test reset ended");
        for (int i = 0; i < 5; i++)
        begin
            gen(32'h0080_0000);
            frm.rc1 = dr1[i];
            frm.rc2 = dr2[i];
            frm.pred_err = dpe[i];
            run();
        end
        $display("test poles ended");
        for (int i = 0; i < 3; i++)
        begin
            gen(fl[i]);
            run();
        end
        $display("test floor ended");
        load('{exp: 16'sh003c, mant: 16'h4000});
        gen(32'h0080_0000);
        run();
        load('{exp: 16'sh0001, mant: 16'h7fff});
        gen(32'h0080_0000);
        run();
        $display("test load ended");
        gen(32'h0040_0000);
        start();
        predict();
        // stay off the edge at which the model copies the frame
        @(negedge sys_clk_i);
        gen(32'h0060_0000);
        start();
        check();
        t = cyc;
        predict();
        check();
        `CHK("done_gap", 12, cyc - t)
        $display("test back_to_back ended");
        for (int i = 0; i < 40; i++)
        begin
            if ($unsigned($random(seed)) % 5 == 0)
                load('{exp: 16'(30 + $unsigned($random(seed)) % 15), mant: 16'h4000 | 16'($random(seed) & 32'h3fff)});
            @(posedge sys_clk_i) adapt_factor_i <= '{exp: 16'($unsigned($random(seed)) % 2),
                mant: 16'h4000 | 16'($random(seed) & 32'h3fff)};
            gen(32'h0010_0000 | ($random(seed) & 32'h007f_ffff));
            run();
        end
        $display("test random ended");
        conclude();
    end
endmodule : vpf_core_tb
